// file: rfs_relay_ctrl.sv
// Purpose: Relay function select and start/stop/reset command decode.
// Assumes: Avalon-MM slave with waitrequest; digital inputs high when closed.
// Notes: Motor phase and alarm state come from elsewhere as levels.
`timescale 1ns/1ps
module rfs_relay_ctrl
   import rfs_pkg::*;
#(
   parameter int unsigned RCB_DELAY_CYC = RCB_DELAY_CYC_DEF
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] din,
   input wire rfs_alarm_t alarm,
   input wire rfs_phase_t phase,
   output logic [2:0] relay_out,
   output logic start_cmd,
   output logic stop_cmd,
   output logic reset_cmd
);
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] func_ff;
   logic [31:0] cont_ff;
   logic [31:0] cfg_ff;
   logic [31:0] nxt_func;
   logic [2:0] relay_ff;
   logic start_ff;
   logic stop_ff;
   logic reset_ff;
   logic stop_latch_ff;
   rfs_run_t run_st_ff;
   logic [1:0] sync1_ff;
   logic [1:0] sync2_ff;
   logic [1:0] deb_ff;
   logic [DEB_CW-1:0] deb_cnt_ff [2];
   logic [1:0] d_prev_ff;
   logic combo_prev_ff;
   logic [SET_CW-1:0] settle_ff;
   logic pwr_ok_ff;
   logic armed_ff;
   logic [RCB_CW-1:0] rcb_cnt_ff;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction

   // Activation condition of one relay for its function code
   function automatic logic fn_act(input logic [4:0] code, input rfs_phase_t ph,
                                   input rfs_alarm_t al, input logic brk_ok);
      logic run_p;
      logic op_p;
      logic pwr_al;
      logic oth_al;
      run_p = ph.starting | ph.full_volt;
      op_p = run_p | ph.stopping;
      pwr_al = al.max_pwr | al.min_pwr;
      oth_al = al.ext | al.general;
      case (code)
         FN_OPER: fn_act = op_p;
         FN_FULLV: fn_act = ph.full_volt;
         FN_PPRE: fn_act = al.max_pre | al.min_pre;
         FN_RCB: fn_act = ph.braking & brk_ok;
         FN_RUN: fn_act = run_p;
         FN_RUN_R: fn_act = run_p & ~ph.dir_left;
         FN_RUN_L: fn_act = run_p & ph.dir_left;
         FN_OPER_R: fn_act = op_p & ~ph.dir_left;
         FN_OPER_L: fn_act = op_p & ph.dir_left;
         FN_PWR_AL: fn_act = pwr_al;
         FN_MAX_AL: fn_act = al.max_pwr;
         FN_MAX_PRE: fn_act = al.max_pre;
         FN_MIN_AL: fn_act = al.min_pwr;
         FN_MIN_PRE: fn_act = al.min_pre;
         FN_ALL_NPRE: fn_act = pwr_al | oth_al;
         FN_ALL_NPWR: fn_act = oth_al;
         FN_EXT: fn_act = al.ext;
         FN_AR_EXP: fn_act = al.ar_expired;
         FN_MANUAL: fn_act = al.manual;
         default: fn_act = 1'b0;
      endcase
   endfunction

   // Bus decode
   logic hit_func;
   logic hit_cont;
   logic hit_cfg;
   logic hit_cmd;
   logic hit_stat;
   logic wr_en;
   logic acc;
   assign hit_func = avs_address == REG_FUNC_OFS;
   assign hit_cont = avs_address == REG_CONT_OFS;
   assign hit_cfg = avs_address == REG_CFG_OFS;
   assign hit_cmd = avs_address == REG_CMD_OFS;
   assign hit_stat = avs_address == REG_STAT_OFS;
   assign acc = (avs_read | avs_write) & wait_ff;
   assign wr_en = avs_write & ~wait_ff;

   logic [31:0] func_wr;
   logic [31:0] cont_wr;
   logic [31:0] cfg_wr;
   logic rcb_rise;
   logic cmd_wr;
   assign func_wr = merge(func_ff, avs_writedata, avs_byteenable) & FUNC_MASK;
   assign cont_wr = merge(cont_ff, avs_writedata, avs_byteenable) & CONT_MASK;
   assign cfg_wr = merge(cfg_ff, avs_writedata, avs_byteenable) & CFG_MASK;
   assign rcb_rise = wr_en & hit_cfg & ~(|cfg_ff[BRK_LSB +: 3]) & (|cfg_wr[BRK_LSB +: 3]);
   assign cmd_wr = wr_en & hit_cmd & avs_byteenable[0];

   always_comb
   begin
      nxt_func = func_ff;
      if (wr_en & hit_func)
      begin
         nxt_func = func_wr;
      end
      if (rcb_rise)
      begin
         nxt_func[FN1_LSB +: 5] = FN_RUN;
         nxt_func[FN2_LSB +: 5] = FN_RCB;
      end
   end

   // Setting fields
   logic [4:0] fn1;
   logic [4:0] fn2;
   logic [4:0] fn3;
   logic nc1;
   logic nc2;
   logic [1:0] src;
   logic [1:0] sch;
   assign fn1 = func_ff[FN1_LSB +: 5];
   assign fn2 = func_ff[FN2_LSB +: 5];
   assign fn3 = func_ff[FN3_LSB +: 5];
   assign nc1 = cont_ff[CT1_LSB +: 2] == CT_NC;
   assign nc2 = cont_ff[CT2_LSB +: 2] == CT_NC;
   assign src = cfg_ff[SRC_LSB +: 2];
   assign sch = cfg_ff[SCH_LSB +: 2];

   // Relay activation, brake held off after run relay drops
   logic rcb_ok;
   logic [2:0] act;
   logic run_any;
   assign rcb_ok = rcb_cnt_ff == RCB_CW'(RCB_DELAY_CYC);
   assign act[0] = fn_act(fn1, phase, alarm, rcb_ok);
   assign act[1] = fn_act(fn2, phase, alarm, rcb_ok);
   assign act[2] = fn_act(fn3, phase, alarm, rcb_ok);
   assign run_any = (act[0] & (fn1 inside {FN_RUN, FN_RUN_R, FN_RUN_L}))
                  | (act[1] & (fn2 inside {FN_RUN, FN_RUN_R, FN_RUN_L}))
                  | (act[2] & (fn3 inside {FN_RUN, FN_RUN_R, FN_RUN_L}));

   // Input conditioning
   for (genvar i = 0; i < 2; i++)
   begin : g_deb
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            sync1_ff[i] <= 1'b0;
            sync2_ff[i] <= 1'b0;
            deb_ff[i] <= 1'b0;
            deb_cnt_ff[i] <= '0;
         end
         else
         begin
            sync1_ff[i] <= din[i];
            sync2_ff[i] <= sync1_ff[i];
            if (sync2_ff[i] == deb_ff[i])
            begin
               deb_cnt_ff[i] <= '0;
            end
            else if (deb_cnt_ff[i] == DEB_CW'(DEB_CYC - 1))
            begin
               deb_cnt_ff[i] <= '0;
               deb_ff[i] <= sync2_ff[i];
            end
            else
            begin
               deb_cnt_ff[i] <= deb_cnt_ff[i] + 1'b1;
            end
         end
      end
   end

   // Edges and remote decode
   logic [1:0] rise;
   logic [1:0] fall;
   logic combo;
   logic combo_rise;
   logic rem_start;
   logic rem_stop;
   logic rem_reset;
   assign rise = deb_ff & ~d_prev_ff;
   assign fall = ~deb_ff & d_prev_ff;
   assign combo = deb_ff[0] & deb_ff[1];
   assign combo_rise = combo & ~combo_prev_ff;
   assign rem_start = ((sch == SCH_2W_AUTO | sch == SCH_2W_SEP) & combo_rise)
                    | ((sch == SCH_3W) & rise[0] & armed_ff);
   assign rem_stop = fall[1];
   assign rem_reset = ((sch == SCH_2W_SEP) & rise[0] & armed_ff)
                    | ((sch != SCH_2W_SEP) & rem_start);

   // Source selection
   logic src_pnl;
   logic src_rem;
   logic src_ser;
   logic pnl_key;
   logic stop_go;
   logic start_go;
   logic reset_go;
   assign src_pnl = src == SRC_PANEL;
   assign src_rem = src == SRC_REMOTE;
   assign src_ser = src == SRC_SERIAL;
   assign pnl_key = cmd_wr & avs_writedata[CMD_PNL_KEY];
   assign stop_go = (src_pnl & pnl_key & (run_st_ff == RUN_ON))
                  | (src_ser & cmd_wr & avs_writedata[CMD_SER_STOP])
                  | (src_rem & rem_stop);
   assign start_go = ~stop_go & ((src_pnl & pnl_key & (run_st_ff == RUN_IDLE))
                  | (src_ser & cmd_wr & avs_writedata[CMD_SER_START])
                  | (src_rem & rem_start));
   assign reset_go = (cmd_wr & avs_writedata[CMD_PNL_RST])
                   | (src_ser & cmd_wr & avs_writedata[CMD_SER_RST])
                   | (src_rem & rem_reset);

   logic [31:0] rd_mux;
   assign rd_mux = hit_func ? func_ff : hit_cont ? cont_ff : hit_cfg ? cfg_ff
                 : hit_stat ? {24'h0, run_st_ff == RUN_ON, rcb_ok, deb_ff, stop_latch_ff, relay_ff}
                 : 32'h0;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end
      else
      begin
         wait_ff <= ~acc;
         if (acc)
         begin
            rdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         func_ff <= FUNC_RST;
         cont_ff <= CONT_RST;
         cfg_ff <= CFG_RST;
      end
      else
      begin
         func_ff <= nxt_func;
         if (wr_en & hit_cont)
         begin
            cont_ff <= cont_wr;
         end
         if (wr_en & hit_cfg)
         begin
            cfg_ff <= cfg_wr;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         relay_ff <= 3'h0;
         rcb_cnt_ff <= '0;
      end
      else
      begin
         relay_ff <= {act[2], act[1] ^ nc2, act[0] ^ nc1};
         if (run_any)
         begin
            rcb_cnt_ff <= '0;
         end
         else if (!rcb_ok)
         begin
            rcb_cnt_ff <= rcb_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         d_prev_ff <= 2'h0;
         combo_prev_ff <= 1'b0;
         settle_ff <= '0;
         pwr_ok_ff <= 1'b0;
         armed_ff <= 1'b0;
      end
      else
      begin
         d_prev_ff <= deb_ff;
         combo_prev_ff <= combo;
         if (!pwr_ok_ff)
         begin
            settle_ff <= settle_ff + 1'b1;
         end
         pwr_ok_ff <= pwr_ok_ff | (settle_ff == SET_CW'(SETTLE_CYC));
         if (pwr_ok_ff & ~deb_ff[0])
         begin
            armed_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
         reset_ff <= 1'b0;
         stop_latch_ff <= 1'b0;
         run_st_ff <= RUN_IDLE;
      end
      else
      begin
         start_ff <= start_go;
         stop_ff <= stop_go;
         reset_ff <= reset_go;
         case (run_st_ff)
            RUN_IDLE:
            begin
               if (start_go)
               begin
                  run_st_ff <= RUN_ON;
               end
            end
            RUN_ON:
            begin
               if (stop_go)
               begin
                  run_st_ff <= RUN_IDLE;
               end
            end
            default: run_st_ff <= RUN_IDLE;
         endcase
         if (stop_go)
         begin
            stop_latch_ff <= 1'b1;
         end
         else if (start_go)
         begin
            stop_latch_ff <= 1'b0;
         end
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata = rdata_ff;
   assign relay_out = relay_ff;
   assign start_cmd = start_ff;
   assign stop_cmd = stop_ff;
   assign reset_cmd = reset_ff;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);

   property p_off_pol;
      (fn1 == FN_OFF) && (fn2 == FN_OFF) |=> relay_out[1:0] == {$past(nc2), $past(nc1)};
   endproperty
   a_off_pol: assert property (p_off_pol) else $error("off relay not at polarity");

   property p_rcb_force;
      rcb_rise |=> (fn1 == FN_RUN) && (fn2 == FN_RCB);
   endproperty
   a_rcb_force: assert property (p_rcb_force) else $error("brake codes not forced");

   property p_src_gate;
      cmd_wr && avs_writedata[CMD_SER_START] && !avs_writedata[CMD_PNL_KEY] && !src_ser && !src_rem
         |=> !start_cmd;
   endproperty
   a_src_gate: assert property (p_src_gate) else $error("start from wrong source");

   property p_pnl_reset;
      cmd_wr && avs_writedata[CMD_PNL_RST] |=> reset_cmd;
   endproperty
   a_pnl_reset: assert property (p_pnl_reset) else $error("panel reset lost");

   property p_pnl_nostart;
      cmd_wr && avs_writedata[CMD_PNL_RST] && !avs_writedata[CMD_PNL_KEY] && src_pnl |=> !start_cmd;
   endproperty
   a_pnl_nostart: assert property (p_pnl_nostart) else $error("panel reset started motor");

   // Separate-reset scheme also resets when the start input itself closed
   property p_two_wire_start;
      src_rem && (sch == SCH_2W_AUTO || sch == SCH_2W_SEP) && combo_rise && !fall[1]
         |=> start_cmd && (reset_cmd == ((sch == SCH_2W_AUTO) || $past(rise[0] && armed_ff)
                                         || $past(cmd_wr && avs_writedata[CMD_PNL_RST])));
   endproperty
   a_two_wire_start: assert property (p_two_wire_start) else $error("2-wire start wrong");

   property p_sep_reset;
      src_rem && (sch == SCH_2W_SEP) && rise[0] && armed_ff |=> reset_cmd;
   endproperty
   a_sep_reset: assert property (p_sep_reset) else $error("separate reset lost");

   property p_stop_edge;
      src_rem && fall[1] |=> stop_cmd ##1 stop_latch_ff;
   endproperty
   a_stop_edge: assert property (p_stop_edge) else $error("remote stop missed");

   property p_no_pwrup_3w;
      src_rem && (sch == SCH_3W) && !armed_ff |=> !start_cmd;
   endproperty
   a_no_pwrup_3w: assert property (p_no_pwrup_3w) else $error("3-wire power-up start");

   property p_brake_delay;
      run_any |=> !rcb_ok [*2];
   endproperty
   a_brake_delay: assert property (p_brake_delay) else $error("brake delay not restarted");
endmodule

// file: rfs_pkg.sv
// Purpose: Shared constants and types for the relay and start/stop block.
// Assumes: 200 MHz system clock, Avalon-MM byte addresses.
// Notes: Function codes, register map and timing counts.
package rfs_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int RCB_DELAY_MS = 500;
   localparam int RCB_DELAY_CYC_DEF = RCB_DELAY_MS * (CLK_HZ / 1000);
   localparam int RCB_CW = 27;
   localparam int DEB_TIME_US = 10;
   localparam int DEB_CYC = DEB_TIME_US * (CLK_HZ / 1_000_000);
   localparam int DEB_CW = 12;
   localparam int SETTLE_CYC = 2 * DEB_CYC + 4;
   localparam int SET_CW = 13;

   localparam logic [7:0] REG_FUNC_OFS = 8'h00;
   localparam logic [7:0] REG_CONT_OFS = 8'h04;
   localparam logic [7:0] REG_CFG_OFS = 8'h08;
   localparam logic [7:0] REG_CMD_OFS = 8'h0c;
   localparam logic [7:0] REG_STAT_OFS = 8'h10;

   localparam logic [31:0] FUNC_RST = 32'h000f_0201;
   localparam logic [31:0] FUNC_MASK = 32'h001f_1f1f;
   localparam logic [31:0] CONT_RST = 32'h0000_0101;
   localparam logic [31:0] CONT_MASK = 32'h0000_0303;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_MASK = 32'h0000_0733;

   localparam int FN1_LSB = 0;
   localparam int FN2_LSB = 8;
   localparam int FN3_LSB = 16;
   localparam int CT1_LSB = 0;
   localparam int CT2_LSB = 8;
   localparam int SRC_LSB = 0;
   localparam int SCH_LSB = 4;
   localparam int BRK_LSB = 8;
   localparam int CMD_PNL_KEY = 0;
   localparam int CMD_PNL_RST = 2;
   localparam int CMD_SER_START = 4;
   localparam int CMD_SER_STOP = 5;
   localparam int CMD_SER_RST = 6;

   localparam logic [4:0] FN_OFF = 5'h00;
   localparam logic [4:0] FN_OPER = 5'h01;
   localparam logic [4:0] FN_FULLV = 5'h02;
   localparam logic [4:0] FN_PPRE = 5'h03;
   localparam logic [4:0] FN_RCB = 5'h04;
   localparam logic [4:0] FN_RUN = 5'h05;
   localparam logic [4:0] FN_RUN_R = 5'h06;
   localparam logic [4:0] FN_RUN_L = 5'h07;
   localparam logic [4:0] FN_OPER_R = 5'h08;
   localparam logic [4:0] FN_OPER_L = 5'h09;
   localparam logic [4:0] FN_PWR_AL = 5'h0a;
   localparam logic [4:0] FN_MAX_AL = 5'h0b;
   localparam logic [4:0] FN_MAX_PRE = 5'h0c;
   localparam logic [4:0] FN_MIN_AL = 5'h0d;
   localparam logic [4:0] FN_MIN_PRE = 5'h0e;
   localparam logic [4:0] FN_ALL_NPRE = 5'h0f;
   localparam logic [4:0] FN_ALL_NPWR = 5'h10;
   localparam logic [4:0] FN_EXT = 5'h11;
   localparam logic [4:0] FN_AR_EXP = 5'h12;
   localparam logic [4:0] FN_MANUAL = 5'h13;

   localparam logic [1:0] CT_NC = 2'h2;
   localparam logic [1:0] SRC_PANEL = 2'h0;
   localparam logic [1:0] SRC_REMOTE = 2'h1;
   localparam logic [1:0] SRC_SERIAL = 2'h2;
   localparam logic [1:0] SCH_2W_AUTO = 2'h0;
   localparam logic [1:0] SCH_2W_SEP = 2'h1;
   localparam logic [1:0] SCH_3W = 2'h2;

   typedef enum logic [1:0] {RUN_IDLE = 2'b01, RUN_ON = 2'b10} rfs_run_t;

   typedef struct packed {
      logic max_pwr;
      logic max_pre;
      logic min_pwr;
      logic min_pre;
      logic ext;
      logic general;
      logic ar_expired;
      logic manual;
   } rfs_alarm_t;

   typedef struct packed {
      logic starting;
      logic full_volt;
      logic stopping;
      logic braking;
      logic dir_left;
   } rfs_phase_t;
endpackage

// file: rfs_switches.sv
// Purpose: Model of the two external switches on the digital inputs.
// Assumes: A closed contact reads 1.
// Notes: Each changed contact chatters before it settles.
`timescale 1ns/1ps
module rfs_switches
(
   input wire logic clk,
   input wire logic [1:0] sw,
   output logic [1:0] din
);
   logic [1:0] lvl_ff = 2'h0;
   logic [1:0] chg_ff = 2'h0;
   logic [1:0] din_ff = 2'h0;
   logic [5:0] chat_ff = 6'h00;
   assign din = din_ff;
   always @(posedge clk)
   begin
      if (sw !== lvl_ff)
      begin
         lvl_ff <= sw;
         chg_ff <= sw ^ lvl_ff;
         chat_ff <= 6'h28;
      end
      else if (chat_ff != 6'h00)
         chat_ff <= chat_ff - 6'h01;
      // Bounce only on the contact that moved
      din_ff <= lvl_ff ^ (chg_ff & {2{chat_ff != 6'h00 && chat_ff[2]}});
   end
endmodule

// file: tb_rfs_relay_ctrl.sv
// Purpose: Self-checking bench for the relay and start/stop block.
// Assumes: Brake delay shortened to 20 cycles.
// Notes: Reads and command pulses are checked against queued notes.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rfs_relay_ctrl
   import rfs_pkg::*;
;
   typedef struct packed {logic [31:0] val; logic [31:0] msk;} rfs_note_t;
   localparam int LIMIT = 80000;
   localparam logic [2:0] E_ST = 3'h4;
   localparam logic [2:0] E_SP = 3'h2;
   localparam logic [2:0] E_RS = 3'h1;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, start_cmd, stop_cmd, reset_cmd;
   logic [1:0] sw = 2'h0;
   logic [1:0] din;
   rfs_alarm_t alarm = 8'h00;
   rfs_phase_t phase = 5'h00;
   logic [2:0] relay_out;
   logic [2:0] ce;
   logic [4:0] fn3;
   rfs_note_t nt;
   rfs_note_t rd_q[$];
   logic [2:0] cmd_q[$];
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;

   rfs_relay_ctrl #(.RCB_DELAY_CYC(20)) u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .din(din), .alarm(alarm), .phase(phase), .relay_out(relay_out), .start_cmd(start_cmd),
      .stop_cmd(stop_cmd), .reset_cmd(reset_cmd));
   rfs_switches u_sw (.clk(clk), .sw(sw), .din(din));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      rd_q.push_back({v, m});
      bus(1'b0, a, 32'h0);
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      tick(16);
      rstn <= 1'b1;
   endtask

   task automatic cmd(input logic [31:0] d, input logic [2:0] e);
      if (e != 3'h0)
         cmd_q.push_back(e);
      bus(1'b1, REG_CMD_OFS, d);
      tick(6);
      `CHK(cmd_q.size(), 0)
   endtask

   task automatic swit(input logic [1:0] s, input logic [2:0] e);
      if (e != 3'h0)
         cmd_q.push_back(e);
      sw <= s;
      tick(2300);
      `CHK(cmd_q.size(), 0)
   endtask

   task automatic rf_case(input logic [4:0] c, input logic [1:0] ct, input rfs_phase_t p,
      input rfs_alarm_t a, input logic [2:0] e);
      bus(1'b1, REG_FUNC_OFS, {11'h0, FN_ALL_NPRE, 3'h0, FN_OFF, 3'h0, c});
      bus(1'b1, REG_CONT_OFS, {30'h0, ct});
      phase <= p;
      alarm <= a;
      tick(4);
      `CHK(relay_out, e)
      rd(REG_STAT_OFS, {29'h0, e}, 32'h7);
   endtask

   // Takes the oldest note whenever read data or a command pulse appears
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         err_count++;
         report_and_stop();
      end
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      begin
         if (rd_q.size() == 0)
            `CHK(1'b1, 1'b0)
         else
         begin
            nt = rd_q.pop_front();
            `CHK(avs_readdata & nt.msk, nt.val)
         end
      end
      if (rstn === 1'b1 && {start_cmd, stop_cmd, reset_cmd} !== 3'h0)
      begin
         ce = (cmd_q.size() == 0) ? 3'h0 : cmd_q.pop_front();
         `CHK({start_cmd, stop_cmd, reset_cmd}, ce)
      end
   end

   initial
   begin
      void'($urandom(32'h2677f90b));
      do_reset();
      rd(REG_FUNC_OFS, FUNC_RST, FUNC_MASK);
      rd(REG_CONT_OFS, CONT_RST, CONT_MASK);
      rd(REG_CFG_OFS, CFG_RST, CFG_MASK);
      rd(REG_STAT_OFS, 32'h0, 32'h7);
      rd(8'h40, 32'h0, 32'hffff_ffff);
      rd(REG_CMD_OFS, 32'h0, 32'hffff_ffff);
      $display("test reset values done");
      for (int c = 0; c < 20; c++)
      begin
         fn3 = c[4:0];
         bus(1'b1, REG_FUNC_OFS, {11'h0, fn3, 3'h0, fn3, 3'h0, fn3});
         rd(REG_FUNC_OFS, {11'h0, fn3, 3'h0, fn3, 3'h0, fn3}, FUNC_MASK);
      end
      rf_case(FN_OFF, 2'h1, 5'h08, 8'h00, 3'h0);
      rf_case(FN_OFF, 2'h2, 5'h00, 8'h00, 3'h1);
      rf_case(FN_OPER, 2'h1, 5'h04, 8'h00, 3'h1);
      rf_case(FN_OPER, 2'h2, 5'h10, 8'h00, 3'h0);
      rf_case(FN_FULLV, 2'h1, 5'h10, 8'h00, 3'h0);
      rf_case(FN_FULLV, 2'h1, 5'h08, 8'h00, 3'h1);
      rf_case(FN_ALL_NPRE, 2'h1, 5'h00, 8'h04, 3'h5);
      rf_case(FN_ALL_NPRE, 2'h1, 5'h00, 8'h50, 3'h0);
      rf_case(FN_ALL_NPWR, 2'h1, 5'h00, 8'h80, 3'h4);
      rf_case(FN_ALL_NPWR, 2'h1, 5'h00, 8'h08, 3'h5);
      $display("test relay functions done");
      fn3 = 5'($urandom_range(19, 1));
      bus(1'b1, REG_FUNC_OFS, {11'h0, fn3, 16'h0101});
      bus(1'b1, REG_CONT_OFS, 32'h0000_0101);
      alarm <= 8'h00;
      phase <= 5'h10;
      bus(1'b1, REG_CFG_OFS, 32'h0000_0200);
      rd(REG_FUNC_OFS, {11'h0, fn3, 3'h0, FN_RCB, 3'h0, FN_RUN}, FUNC_MASK);
      rd(REG_STAT_OFS, 32'h1, 32'h3);
      phase <= 5'h02;
      tick(2);
      rd(REG_STAT_OFS, 32'h0, 32'h3);
      tick(25);
      rd(REG_STAT_OFS, 32'h2, 32'h3);
      phase <= 5'h00;
      bus(1'b1, REG_FUNC_OFS, FUNC_RST);
      rd(REG_FUNC_OFS, FUNC_RST, FUNC_MASK);
      $display("test reverse brake done");
      cmd(32'h1, E_ST);
      cmd(32'h1, E_SP);
      cmd(32'h10, 3'h0);
      cmd(32'h4, E_RS);
      bus(1'b1, REG_CFG_OFS, 32'h0000_0202);
      cmd(32'h10, E_ST);
      cmd(32'h1, 3'h0);
      cmd(32'h4, E_RS);
      cmd(32'h40, E_RS);
      cmd(32'h20, E_SP);
      bus(1'b1, REG_CFG_OFS, 32'h0000_0201);
      cmd(32'h10, 3'h0);
      cmd(32'h4, E_RS);
      $display("test command sources done");
      // Jumper joins the two inputs
      swit(2'h3, E_ST | E_RS);
      swit(2'h0, E_SP);
      bus(1'b1, REG_CFG_OFS, 32'h0000_0211);
      swit(2'h1, E_RS);
      swit(2'h3, E_ST);
      swit(2'h2, 3'h0);
      // Start input closing again with stop closed makes both closed once more
      swit(2'h3, E_ST | E_RS);
      swit(2'h1, E_SP);
      swit(2'h0, 3'h0);
      $display("test two-wire schemes done");
      sw <= 2'h3;
      do_reset();
      bus(1'b1, REG_CFG_OFS, 32'h0000_0001);
      cmd_q.push_back(E_ST | E_RS);
      tick(6000);
      `CHK(cmd_q.size(), 0)
      rd(REG_STAT_OFS, 32'h80, 32'h80);
      do_reset();
      bus(1'b1, REG_CFG_OFS, 32'h0000_0021);
      tick(6000);
      rd(REG_STAT_OFS, 32'h0, 32'h80);
      swit(2'h2, 3'h0);
      swit(2'h3, E_ST | E_RS);
      swit(2'h2, 3'h0);
      swit(2'h0, E_SP);
      swit(2'h2, 3'h0);
      rd(REG_STAT_OFS, 32'h08, 32'h88);
      $display("test three-wire scheme done");
      report_and_stop();
   end
endmodule
